/* logic/lcs_clock_select.v */
// clock generation and selection as clock enables on the primary clock clk_i
// assumes straps stable through reset and a classic wishbone single master
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.vh"
module lcs_clock_select
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // pins
    input wire [1:0] bus_divider_straps_i,
    input wire secondary_input_clock_i,
    // derived clock enables and backlight modulation output
    output reg bus_clk_en_o,
    output reg mem_clk_en_o,
    output reg pix_clk_en_o,
    output reg modulator_clock_en_o,
    output reg backlight_modulation_output_o
);
    // ==========================================================
    // registers
    reg [1:0] strap_code;
    reg [7:0] mem_cfg;
    reg [7:0] pix_cfg;
    reg [7:0] func_en;
    reg [7:0] pwm_duty;
    reg pwm_sel;
    reg in_reset;
    reg sec_q1;
    reg sec_q2;
    reg sec_q3;
    reg [7:0] pwm_cnt;
    wire bus_en;
    wire mem_en;
    wire pix_en;
    reg pix_tick;
    reg pwm_tick;
    wire wb_req;
    wire [7:0] idx;
    wire mem_run;
    wire lcd_run;
    wire pwm_run;

    // pixel divisor code 0..4 means 1,2,3,4,8; others fall back to 1
    function [3:0] pix_div;
        input [3:0] code;
        begin
            case (code)
                4'h0: pix_div = 4'h1;
                4'h1: pix_div = 4'h2;
                4'h2: pix_div = 4'h3;
                4'h3: pix_div = 4'h4;
                4'h4: pix_div = 4'h8;
                default: pix_div = 4'h1;
            endcase
        end
    endfunction

    // ==========================================================
    // strap capture: sampled every reset cycle, frozen at release
    always @(posedge clk_i)
    begin
        in_reset <= rst_i;
        if (rst_i)
            strap_code <= bus_divider_straps_i;
    end

    // ==========================================================
    // secondary clock edge detect; first stage feeds only the second
    always @(posedge clk_i)
    begin
        // the chain follows the pin through reset as well, so a pin that idles
        // high brings no false edge at release
        sec_q1 <= secondary_input_clock_i;
        sec_q2 <= sec_q1;
        sec_q3 <= sec_q2;
    end

    wire sec_tick = sec_q2 & ~sec_q3;

    // ==========================================================
    // gating by function: bus always runs, the rest follow enables
    assign mem_run = func_en[`LCS_FN_MEM] | func_en[`LCS_FN_LCD];
    assign lcd_run = func_en[`LCS_FN_LCD];
    assign pwm_run = func_en[`LCS_FN_PWM];

    lcs_divider u_bus
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(1'b1),
        .run_i(~in_reset),
        .div_i({2'b00, strap_code} + 4'h1),
        .en_o(bus_en)
    );

    lcs_divider u_mem
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(bus_en),
        .run_i(mem_run),
        .div_i({2'b00, mem_cfg[`LCS_MEM_DIV_HI:`LCS_MEM_DIV_LO]} + 4'h1),
        .en_o(mem_en)
    );

    // pixel source mux from the low nibble
    always @*
    begin
        case (pix_cfg[3:0])
            `LCS_SRC_MEM: pix_tick = mem_en;
            `LCS_SRC_BUS: pix_tick = bus_en;
            `LCS_SRC_PRI: pix_tick = 1'b1;
            `LCS_SRC_SEC: pix_tick = sec_tick;
            default: pix_tick = mem_en;
        endcase
    end

    lcs_divider u_pix
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(pix_tick),
        .run_i(lcd_run),
        .div_i(pix_div(pix_cfg[7:4])),
        .en_o(pix_en)
    );

    // modulator source: primary or secondary input
    always @*
    begin
        if (pwm_sel)
            pwm_tick = sec_tick;
        else
            pwm_tick = 1'b1;
    end

    // ==========================================================
    // output flops and backlight modulator
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_clk_en_o <= 1'b0;
            mem_clk_en_o <= 1'b0;
            pix_clk_en_o <= 1'b0;
            modulator_clock_en_o <= 1'b0;
            backlight_modulation_output_o <= 1'b0;
            pwm_cnt <= 8'h00;
        end
        else
        begin
            bus_clk_en_o <= bus_en;
            mem_clk_en_o <= mem_en;
            pix_clk_en_o <= pix_en;
            modulator_clock_en_o <= pwm_run & pwm_tick;
            if (!pwm_run)
            begin
                pwm_cnt <= 8'h00;
                backlight_modulation_output_o <= 1'b0;
            end
            else if (pwm_tick)
            begin
                pwm_cnt <= pwm_cnt + 8'h01;
                backlight_modulation_output_o <= (pwm_cnt < pwm_duty);
            end
        end
    end

    // ==========================================================
    // wishbone slave: ack one cycle after request, dropped next cycle
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx = wb_adr_i[9:2];

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            mem_cfg <= `LCS_RST_MEMCLK;
            pix_cfg <= `LCS_RST_PIXCLK;
            func_en <= `LCS_RST_FUNC;
            pwm_duty <= `LCS_RST_PWMDUTY;
            pwm_sel <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && wb_we_i && wb_sel_i[0])
            begin
                case (idx)
                    `LCS_IDX_MEMCLK: mem_cfg <= wb_dat_i[7:0] & 8'h30;
                    `LCS_IDX_PIXCLK: pix_cfg <= wb_dat_i[7:0] & 8'h73;
                    `LCS_IDX_FUNC: func_en <= wb_dat_i[7:0] & 8'h07;
                    `LCS_IDX_PWMDUTY: pwm_duty <= wb_dat_i[7:0];
                    `LCS_IDX_PWMSEL: pwm_sel <= wb_dat_i[0];
                    default: ;
                endcase
            end
            if (wb_req && !wb_we_i)
            begin
                case (idx)
                    `LCS_IDX_MEMCLK: wb_dat_o <= {24'h000000, mem_cfg};
                    `LCS_IDX_PIXCLK: wb_dat_o <= {24'h000000, pix_cfg};
                    `LCS_IDX_FUNC: wb_dat_o <= {24'h000000, func_en};
                    `LCS_IDX_STATUS: wb_dat_o <= {26'h0000000, strap_code,
                        1'b0, pwm_run, lcd_run, mem_run};
                    `LCS_IDX_PWMDUTY: wb_dat_o <= {24'h000000, pwm_duty};
                    `LCS_IDX_PWMSEL: wb_dat_o <= {31'h00000000, pwm_sel};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // lcs_clock_select
`default_nettype wire

/* logic/lcs_defines.vh */
// constants for the lcd clock select block: register offsets, fields, resets
// assumes the includer has set up timescale and nettype
`ifndef LCS_DEFINES_VH
`define LCS_DEFINES_VH

// ==========================================================
// register word offsets (byte address = 4 * index)
`define LCS_IDX_MEMCLK   8'h04
`define LCS_IDX_PIXCLK   8'h05
`define LCS_IDX_FUNC     8'h40
`define LCS_IDX_STATUS   8'h41
`define LCS_IDX_PWMCFG   8'h42
`define LCS_IDX_PWMDUTY  8'h43
`define LCS_IDX_PWMSEL   8'hb1

// ==========================================================
// fields
`define LCS_MEM_DIV_HI   5
`define LCS_MEM_DIV_LO   4
`define LCS_FN_MEM       0
`define LCS_FN_LCD       1
`define LCS_FN_PWM       2

// ==========================================================
// reset values
`define LCS_RST_MEMCLK   8'h00
`define LCS_RST_PIXCLK   8'h00
`define LCS_RST_FUNC     8'h00
`define LCS_RST_PWMDUTY  8'h80

// ==========================================================
// pixel source codes
`define LCS_SRC_MEM      4'h0
`define LCS_SRC_BUS      4'h1
`define LCS_SRC_PRI      4'h2
`define LCS_SRC_SEC      4'h3

`endif

/* logic/lcs_divider.v */
// one clock-enable divider: pulses en_o once every div_i input ticks
// assumes div_i is only taken at a period boundary so no runt period results
`timescale 1ns/1ps
`default_nettype none
module lcs_divider
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // control
    input wire tick_i,
    input wire run_i,
    input wire [3:0] div_i,
    // output
    output reg en_o
);
    reg [3:0] cnt;
    reg [3:0] div_held;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 4'h0;
            div_held <= 4'h1;
            en_o <= 1'b0;
        end
        else if (!run_i)
        begin
            // gated: restart cleanly so the first period after enable is whole
            cnt <= 4'h0;
            div_held <= div_i;
            en_o <= 1'b0;
        end
        else if (tick_i)
        begin
            if (cnt + 4'h1 >= div_held)
            begin
                cnt <= 4'h0;
                div_held <= div_i;
                en_o <= 1'b1;
            end
            else
            begin
                cnt <= cnt + 4'h1;
                en_o <= 1'b0;
            end
        end
        else
        begin
            en_o <= 1'b0;
        end
    end
endmodule // lcs_divider
`default_nettype wire

/* dv/lcs_clock_select_properties.sv */
// port assertions for the clock select block
// assumes straps change only while reset is high
`timescale 1ns/1ps
`default_nettype none
module lcs_clock_select_properties
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // clocks
    input wire [1:0] bus_divider_straps_i,
    input wire bus_clk_en_o,
    input wire mem_clk_en_o,
    input wire pix_clk_en_o,
    input wire modulator_clock_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [1:0] s = bus_divider_straps_i;
    wire b = bus_clk_en_o;
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data without ack");
    a_start_gated: assert property ($fell(rst_i) |-> !(b || mem_clk_en_o
        || pix_clk_en_o || modulator_clock_en_o)) else $error("clock at reset");
    a_bus_div1: assert property (s == 2'h0 && b |=> b)
        else $error("bus div1");
    a_bus_div2: assert property (s == 2'h1 && b |=> !b ##1 b)
        else $error("bus div2");
    a_bus_div3: assert property (s == 2'h2 && b |=> !b [*2] ##1 b)
        else $error("bus div3");
    a_bus_div4: assert property (s == 2'h3 && b |=> !b [*3] ##1 b)
        else $error("bus div4");
    a_mem_slow: assert property (s == 2'h1 && mem_clk_en_o |=> !mem_clk_en_o)
        else $error("memory faster than bus");
endmodule // lcs_clock_select_properties
bind lcs_clock_select lcs_clock_select_properties i_lcs_clock_select_properties
(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .bus_divider_straps_i,
.bus_clk_en_o, .mem_clk_en_o, .pix_clk_en_o, .modulator_clock_en_o);
`default_nettype wire

/* dv/lcs_clock_select_tb.sv */
// self-checking bench: wishbone register access and pulse counts of each enable
// assumes one-cycle ack; counts use windows that hold whole periods
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.vh"
module lcs_clock_select_tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg we = 1'b0;
    reg [3:0] sel = 4'hf;
    reg [9:0] adr = 10'h0;
    reg [31:0] wdat = 32'h0;
    reg [1:0] straps = 2'h0;
    reg [2:0] sec = 3'h0;
    wire [31:0] rdat;
    wire ack, eb, em, ep, eo, pwm;
    integer num_errors = 0;
    integer check_count = 0;
    integer c [0:4];
    integer i, h, l, sp, dv, ci;
    reg [31:0] d;
    lcs_clock_select i_lcs_clock_select (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .bus_divider_straps_i(straps),
        .secondary_input_clock_i(sec[2]), .bus_clk_en_o(eb), .mem_clk_en_o(em),
        .pix_clk_en_o(ep), .modulator_clock_en_o(eo), .backlight_modulation_output_o(pwm));
    always #2.5 clk_i = ~clk_i;
    // own loop variable: the test sequence uses i from time zero as well
    initial for (ci = 0; ci < 5; ci = ci + 1) c[ci] = 0;
    // ====
    // secondary clock has a period of 8 primary cycles
    // counting stops in reset so unknown outputs before the first edge stay out
    always @(posedge clk_i)
    begin
        sec <= sec + 3'h1;
        if (!rst_i)
        begin
            c[0] <= c[0] + eb;
            c[1] <= c[1] + em;
            c[2] <= c[2] + ep;
            c[3] <= c[3] + eo;
            c[4] <= c[4] + pwm;
        end
    end
    task chk(input [8*6-1:0] n, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e)
            begin
                num_errors = num_errors + 1;
                $display("Error %0s expected %0h seen %0h", n, e, g);
            end
        end
    endtask
    task wb(input w, input [7:0] x, input [31:0] v, input [3:0] s);
        integer t;
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            we <= w;
            adr <= {x, 2'b00};
            wdat <= v;
            sel <= s;
            t = 0;
            @(posedge clk_i);
            while (ack !== 1'b1 && t < 20)
            begin
                @(posedge clk_i);
                t = t + 1;
            end
            chk("ack", 1'b1, ack);
            d = rdat;
            cyc <= 1'b0;
        end
    endtask
    task rd(input [7:0] x, input [31:0] e);
        begin
            wb(1'b0, x, 32'h0, 4'hf);
            chk("read", e, d);
        end
    endtask
    // ====
    // settle for the longest period, then count over 96 or 256 edges
    task cnt(input [2:0] k, input integer w, input [31:0] e);
        integer s0;
        begin
            repeat (80) @(posedge clk_i);
            #1 s0 = c[k];
            repeat (w) @(posedge clk_i);
            #1 chk("pulses", e, c[k] - s0);
        end
    endtask
    task reboot(input [1:0] s);
        begin
            @(posedge clk_i);
            rst_i <= 1'b1;
            straps <= s;
            repeat (12) @(posedge clk_i);
            rst_i <= 1'b0;
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        #100000;
        num_errors = num_errors + 1;
        summarize;
    end
    initial
    begin
        // straps 00 come first: an undivided bus clock, as a synchronous host wants
        // divide by 3 and 4 only see lone reads, never back-to-back cycles
        for (i = 0; i < 4; i = i + 1)
        begin
            reboot(i[1:0]);
            cnt(0, 96, 96 / (i + 1));
            cnt(1, 96, 0);
            rd(`LCS_IDX_STATUS, i << 4);
        end
        reboot(2'h1);
        rd(`LCS_IDX_MEMCLK, `LCS_RST_MEMCLK);
        rd(`LCS_IDX_PIXCLK, `LCS_RST_PIXCLK);
        rd(`LCS_IDX_FUNC, `LCS_RST_FUNC);
        rd(`LCS_IDX_PWMDUTY, `LCS_RST_PWMDUTY);
        wb(1'b1, 8'h3f, 32'hff, 4'hf);
        rd(8'h3f, 32'h0);
        wb(1'b1, `LCS_IDX_FUNC, 32'h1, 4'he);
        rd(`LCS_IDX_FUNC, 32'h0);
        wb(1'b1, `LCS_IDX_FUNC, 32'h1, 4'hf);
        for (i = 0; i < 4; i = i + 1)
        begin
            wb(1'b1, `LCS_IDX_MEMCLK, i << 4, 4'hf);
            cnt(1, 96, 48 / (i + 1));
            cnt(2, 96, 0);
        end
        wb(1'b1, `LCS_IDX_MEMCLK, 32'h10, 4'hf);
        wb(1'b1, `LCS_IDX_FUNC, 32'h3, 4'hf);
        rd(`LCS_IDX_STATUS, 32'h13);
        for (h = 0; h < 6; h = h + 1)
            for (l = 0; l < 4; l = l + 1)
            begin
                sp = (l == 0) ? 4 : (l == 1) ? 2 : (l == 2) ? 1 : 8;
                dv = (h == 4) ? 8 : (h == 5) ? 1 : h + 1;
                wb(1'b1, `LCS_IDX_PIXCLK, h * 16 + l, 4'hf);
                rd(`LCS_IDX_PIXCLK, h * 16 + l);
                if (sp * dv < 64)
                    cnt(2, 96, 96 / (sp * dv));
            end
        cnt(3, 96, 0);
        wb(1'b1, `LCS_IDX_FUNC, 32'h4, 4'hf);
        cnt(2, 96, 0);
        cnt(1, 96, 0);
        wb(1'b1, `LCS_IDX_PWMSEL, 32'h0, 4'hf);
        cnt(3, 96, 96);
        cnt(4, 256, 128);
        wb(1'b1, `LCS_IDX_PWMDUTY, 32'h40, 4'hf);
        cnt(4, 256, 64);
        wb(1'b1, `LCS_IDX_PWMSEL, 32'h1, 4'hf);
        cnt(3, 96, 12);
        summarize;
    end
endmodule // lcs_clock_select_tb
`default_nettype wire
